//--- src/pbe_defines.vh
// What this block does
// R1: Unprotected sector's status byte reads all ones
// R2: Protected sector's status byte reads all zeros
// R3: Eight-bit volatile protection status, resets all ones
// R4: Enabled boot read starts after every reset
// R5: Bits 31 to 9 give boot start address
// R6: Bits 8 to 1 give initial wait cycles
// R7: Host uses zero delay only up to 50 MHz
// R8: Host uses delay one or more to 166 MHz
// R9: Host uses delay five or more in octal
// R10: Bit 0 enables boot read, default off, kept
// R11: Low 23 bits count erases of addressed sector
// R12: Bit 23 set when count found corrupt, reset
// R13: Corrupt flag cleared by next good erase
// R14: Flag reads 1 invalid, 0 valid count
// R15: Count and flag volatile, read-only, reset zero
// R16: Boot data streams on while select stays low
`ifndef PBE_DEFINES_VH
`define PBE_DEFINES_VH

// ----------------------------------------------------------------
// Register selects
// ----------------------------------------------------------------
`define PBE_SEL_DYN      2'h0
`define PBE_SEL_BOOT     2'h1
`define PBE_SEL_ERASE    2'h2

// ----------------------------------------------------------------
// Field layouts and values
// ----------------------------------------------------------------
`define PBE_DYN_OPEN     8'hFF
`define PBE_DYN_LOCKED   8'h00
`define PBE_DYN_HI       7
`define PBE_ADDR_HI      31
`define PBE_ADDR_LO      9
`define PBE_ADDR_PAD     9'h000
`define PBE_DLY_HI       8
`define PBE_DLY_LO       1
`define PBE_EN_BIT       0
`define PBE_CNT_HI       22
`define PBE_CORRUPT_BIT  23
`define PBE_CNT_ONE      23'h000001
`define PBE_CNT_MAX      23'h7FFFFF
`define PBE_WORD_ZERO    24'h000000
`define PBE_WORD_BAD     24'h800000
`define PBE_CFG_DEFAULT  32'h00000000
`define PBE_ADDR_ONE     32'h00000001
`define PBE_DLY_ZERO     8'h00
`define PBE_DLY_ONE      8'h01

`endif

//--- src/pbe_cnt_mem.v
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Per-sector erase count store, registered read
// ----------------------------------------------------------------
module pbe_cnt_mem #(
  parameter WIDTH = 24,
  parameter DEPTH = 128,
  parameter AW    = 7
) (
  input  wire             clock,
  input  wire             sys_rst,
  input  wire             rd_en,
  input  wire [AW-1:0]    rd_addr,
  output reg  [WIDTH-1:0] rd_data,
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      clr_q;
  wire            clearing;

  // Contents are volatile: walk through and zero after reset
  assign clearing = ~clr_q[AW];

  always @(posedge clock) begin
    if (sys_rst) begin
      clr_q <= {(AW+1){1'b0}};
    end else if (clearing) begin
      clr_q <= clr_q + 1'b1;
    end
  end

  always @(posedge clock) begin
    if (clearing) begin
      mem[clr_q[AW-1:0]] <= {WIDTH{1'b0}};
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      rd_data <= {WIDTH{1'b0}};
    end else if (rd_en) begin
      rd_data <= clearing ? {WIDTH{1'b0}} : mem[rd_addr];
    end
  end
endmodule

//--- src/pbe_regs.v
`timescale 1ns/100ps
`include "pbe_defines.vh"
// ----------------------------------------------------------------
// Protection status, boot read config and erase counters
// ----------------------------------------------------------------
module pbe_regs #(
  parameter NUM_SECTORS = 128,
  parameter SEC_W       = 7
) (
  input  wire                   clock,
  input  wire                   sys_rst,
  input  wire                   reg_rd,
  input  wire                   reg_wr,
  input  wire [1:0]             reg_sel,
  input  wire [SEC_W-1:0]       reg_sector,
  input  wire [31:0]            reg_wdata,
  output reg  [31:0]            reg_rdata,
  output reg                    reg_rvalid,
  input  wire [31:0]            nv_cfg_image,
  output reg  [31:0]            nv_cfg_wdata,
  output reg                    nv_cfg_wr,
  output reg  [NUM_SECTORS-1:0] sector_unlocked,
  input  wire                   erase_done,
  input  wire                   erase_ok,
  input  wire [SEC_W-1:0]       erase_sector,
  input  wire                   count_corrupt,
  input  wire [SEC_W-1:0]       corrupt_sector,
  input  wire                   cs_n_pin,
  input  wire                   sck_pin,
  output reg                    array_rd,
  output reg  [31:0]            array_addr,
  input  wire [7:0]             array_rdata,
  output reg  [7:0]             boot_dout,
  output reg                    boot_dout_oe,
  output wire                   boot_busy
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [7:0] dyn_byte;
    input bit_val;
    begin
      dyn_byte = bit_val ? `PBE_DYN_OPEN : `PBE_DYN_LOCKED; // R1 R2
    end
  endfunction

  function [31:0] boot_start;
    input [31:0] cfg;
    begin
      boot_start = {cfg[`PBE_ADDR_HI:`PBE_ADDR_LO], `PBE_ADDR_PAD}; // R5
    end
  endfunction

  // ----------------------------------------------------------------
  // Dynamic protection bits and boot configuration
  // ----------------------------------------------------------------
  reg  [31:0] boot_cfg_q;
  wire        wr_dyn  = reg_wr & (reg_sel == `PBE_SEL_DYN);
  wire        wr_boot = reg_wr & (reg_sel == `PBE_SEL_BOOT);

  always @(posedge clock) begin
    if (sys_rst) begin
      sector_unlocked <= {NUM_SECTORS{1'b1}}; // R3
    end else if (wr_dyn) begin
      sector_unlocked[reg_sector] <=
        (reg_wdata[`PBE_DYN_HI:0] == `PBE_DYN_OPEN);
    end
  end

  // Reset reloads the stored image, so settings survive resets
  always @(posedge clock) begin
    if (sys_rst) begin
      boot_cfg_q <= nv_cfg_image; // R10
    end else if (wr_boot) begin
      boot_cfg_q <= reg_wdata;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      nv_cfg_wr    <= 1'b0;
      nv_cfg_wdata <= `PBE_CFG_DEFAULT;
    end else begin
      nv_cfg_wr <= wr_boot;
      if (wr_boot) begin
        nv_cfg_wdata <= reg_wdata; // R10
      end
    end
  end

  // ----------------------------------------------------------------
  // Erase counter update and register read path
  // ----------------------------------------------------------------
  reg              er_wb_q;
  reg  [SEC_W-1:0] er_sec_q;
  reg              cp_pend_q;
  reg  [SEC_W-1:0] cp_sec_q;
  reg              rr_pend_q;
  reg  [1:0]       rr_sel_q;
  reg  [SEC_W-1:0] rr_sec_q;
  reg              rr_out_q;
  wire [23:0]      mem_rdata;
  reg              mem_wr;
  reg  [SEC_W-1:0] mem_waddr;
  reg  [23:0]      mem_wdata;
  wire             er_start = erase_done & erase_ok; // R13
  wire             rr_issue = rr_pend_q & ~er_start;
  wire             cp_now   = count_corrupt | cp_pend_q;
  wire [SEC_W-1:0] cp_sec   = count_corrupt ? corrupt_sector : cp_sec_q;
  // Erase read saw the word before the corrupt mark; drop its write-back
  wire             er_keep  = er_start & ~(cp_now && cp_sec == erase_sector);
  wire [22:0]      cnt_old  = mem_rdata[`PBE_CNT_HI:0];
  wire [22:0]      cnt_new  = (cnt_old == `PBE_CNT_MAX) ? cnt_old :
                              cnt_old + `PBE_CNT_ONE;

  // Write port: erase write-back first; a corrupt report on another
  // sector waits one slot. On the same sector the corrupt mark wins.
  always @* begin
    mem_wr    = 1'b0;
    mem_waddr = er_sec_q;
    mem_wdata = `PBE_WORD_ZERO;
    if (er_wb_q && !(cp_now && cp_sec == er_sec_q)) begin
      mem_wr    = 1'b1;
      mem_wdata = {1'b0, cnt_new}; // R11 R13
    end else if (cp_now) begin
      mem_wr    = 1'b1;
      mem_waddr = cp_sec;
      mem_wdata = `PBE_WORD_BAD; // R12 R14
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      er_wb_q   <= 1'b0;
      er_sec_q  <= {SEC_W{1'b0}};
      cp_pend_q <= 1'b0;
      cp_sec_q  <= {SEC_W{1'b0}};
    end else begin
      er_wb_q <= er_keep; // R12
      if (er_start) begin
        er_sec_q <= erase_sector;
      end
      // Keep a corrupt report that lost the write port this cycle
      if (cp_now && mem_wr && mem_waddr != cp_sec) begin
        cp_pend_q <= 1'b1;
        cp_sec_q  <= cp_sec;
      end else begin
        cp_pend_q <= 1'b0;
      end
    end
  end

  pbe_cnt_mem #(
    .WIDTH (24),
    .DEPTH (NUM_SECTORS),
    .AW    (SEC_W)
  ) u_cnt_mem (
    .clock   (clock),
    .sys_rst (sys_rst),
    .rd_en   (er_start | rr_issue),
    .rd_addr (er_start ? erase_sector : rr_sec_q),
    .rd_data (mem_rdata),
    .wr_en   (mem_wr),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata)
  );

  always @(posedge clock) begin
    if (sys_rst) begin
      rr_pend_q <= 1'b0;
      rr_sel_q  <= `PBE_SEL_DYN;
      rr_sec_q  <= {SEC_W{1'b0}};
      rr_out_q  <= 1'b0;
    end else begin
      rr_out_q <= rr_issue;
      if (rr_issue) begin
        rr_pend_q <= 1'b0;
      end else if (reg_rd && !rr_pend_q && !rr_out_q) begin
        rr_pend_q <= 1'b1;
        rr_sel_q  <= reg_sel;
        rr_sec_q  <= reg_sector;
      end
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      reg_rvalid <= 1'b0;
      reg_rdata  <= `PBE_CFG_DEFAULT;
    end else begin
      reg_rvalid <= rr_out_q;
      if (rr_out_q) begin
        if (rr_sel_q == `PBE_SEL_DYN) begin
          reg_rdata <= {`PBE_WORD_ZERO,
                        dyn_byte(sector_unlocked[rr_sec_q])}; // R1 R2
        end else if (rr_sel_q == `PBE_SEL_BOOT) begin
          reg_rdata <= boot_cfg_q;
        end else if (rr_sel_q == `PBE_SEL_ERASE) begin
          reg_rdata <= {8'h00, mem_rdata}; // R11 R14 R15
        end else begin
          reg_rdata <= `PBE_CFG_DEFAULT;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg cs_s1_q, cs_s2_q, sck_s1_q, sck_s2_q, sck_prev_q;
  wire sck_fall = sck_prev_q & ~sck_s2_q;

  always @(posedge clock) begin
    if (sys_rst) begin
      cs_s1_q    <= 1'b1;
      cs_s2_q    <= 1'b1;
      sck_s1_q   <= 1'b0;
      sck_s2_q   <= 1'b0;
      sck_prev_q <= 1'b0;
    end else begin
      cs_s1_q    <= cs_n_pin;
      cs_s2_q    <= cs_s1_q;
      sck_s1_q   <= sck_pin;
      sck_s2_q   <= sck_s1_q;
      sck_prev_q <= sck_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // Boot read sequencer
  // ----------------------------------------------------------------
  localparam [2:0] ST_CHECK  = 3'h0;
  localparam [2:0] ST_ARM    = 3'h1;
  localparam [2:0] ST_DELAY  = 3'h2;
  localparam [2:0] ST_STREAM = 3'h3;
  localparam [2:0] ST_DONE   = 3'h4;

  reg  [2:0] state_q;
  reg  [7:0] dly_cnt_q;
  reg  [7:0] next_byte_q;
  reg        fetch_q;
  wire [7:0] dly_cfg = boot_cfg_q[`PBE_DLY_HI:`PBE_DLY_LO];

  assign boot_busy = (state_q != ST_DONE);

  always @(posedge clock) begin
    if (sys_rst) begin
      state_q      <= ST_CHECK;
      dly_cnt_q    <= `PBE_DLY_ZERO;
      next_byte_q  <= `PBE_DLY_ZERO;
      fetch_q      <= 1'b0;
      array_rd     <= 1'b0;
      array_addr   <= `PBE_CFG_DEFAULT;
      boot_dout    <= `PBE_DLY_ZERO;
      boot_dout_oe <= 1'b0;
    end else begin
      array_rd <= 1'b0;
      fetch_q  <= array_rd;
      if (fetch_q) begin
        next_byte_q <= array_rdata;
      end
      case (state_q)
        ST_CHECK: begin
          // Entered from every reset, power-on or hardware
          if (boot_cfg_q[`PBE_EN_BIT]) begin // R4 R10
            state_q    <= ST_ARM;
            array_addr <= boot_start(boot_cfg_q); // R5
            array_rd   <= 1'b1;
          end else begin
            state_q <= ST_DONE;
          end
        end
        ST_ARM: begin
          if (!cs_s2_q) begin
            state_q   <= ST_DELAY;
            dly_cnt_q <= `PBE_DLY_ZERO;
          end
        end
        ST_DELAY: begin
          if (cs_s2_q) begin
            state_q <= ST_DONE;
          end else if (sck_fall) begin
            if (dly_cnt_q == dly_cfg) begin // R6
              state_q      <= ST_STREAM;
              boot_dout    <= next_byte_q;
              boot_dout_oe <= 1'b1;
              array_addr   <= array_addr + `PBE_ADDR_ONE;
              array_rd     <= 1'b1;
            end else begin
              dly_cnt_q <= dly_cnt_q + `PBE_DLY_ONE;
            end
          end
        end
        ST_STREAM: begin
          // Select release is the only way out of the stream
          if (cs_s2_q) begin
            state_q      <= ST_DONE;
            boot_dout_oe <= 1'b0;
          end else if (sck_fall) begin
            boot_dout  <= next_byte_q; // R16
            array_addr <= array_addr + `PBE_ADDR_ONE;
            array_rd   <= 1'b1;
          end
        end
        default: begin
          state_q      <= ST_DONE;
          boot_dout_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule

//--- test/pbe_props.sv
`timescale 1ns/100ps
module pbe_props #(
  parameter NUM_SECTORS = 128,
  parameter SEC_W       = 7
) (
  input wire                   clock,
  input wire                   sys_rst,
  input wire                   reg_rd,
  input wire                   reg_wr,
  input wire [1:0]             reg_sel,
  input wire [31:0]            reg_wdata,
  input wire                   reg_rvalid,
  input wire [31:0]            nv_cfg_image,
  input wire [31:0]            nv_cfg_wdata,
  input wire                   nv_cfg_wr,
  input wire [NUM_SECTORS-1:0] sector_unlocked,
  input wire                   cs_n_pin,
  input wire                   array_rd,
  input wire [31:0]            array_addr,
  input wire                   boot_dout_oe,
  input wire                   boot_busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // Expected next boot fetch address
  // ------------------------------------------------------------
  reg        seen_q;
  reg [31:0] nxt_q;
  always @(posedge clock) begin
    if (sys_rst) begin
      seen_q <= 1'b0;
      nxt_q  <= 32'h00000000;
    end else if (array_rd) begin
      seen_q <= 1'b1;
      nxt_q  <= array_addr + 32'h00000001;
    end
  end
  property p_rd_lat;
    $rose(reg_rd) |-> ##[3:4] reg_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read late");
  property p_unl_rst;
    $fell(sys_rst) |-> &sector_unlocked;
  endproperty
  a_unl_rst: assert property (p_unl_rst) else $error("unlock rst");
  property p_boot_go;
    $fell(sys_rst) && nv_cfg_image[0] |-> ##[1:2]
      (array_rd && array_addr == {nv_cfg_image[31:9], 9'h000});
  endproperty
  a_boot_go: assert property (p_boot_go) else $error("no boot");
  property p_boot_off;
    $fell(sys_rst) && !nv_cfg_image[0] |-> ##[1:2] !boot_busy;
  endproperty
  a_boot_off: assert property (p_boot_off) else $error("boot on");
  property p_cfg_wr;
    reg_wr && reg_sel == 2'h1 |=>
      nv_cfg_wr && nv_cfg_wdata == $past(reg_wdata);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("cfg store");
  property p_cfg_only;
    nv_cfg_wr |-> $past(reg_wr) && $past(reg_sel) == 2'h1;
  endproperty
  a_cfg_only: assert property (p_cfg_only) else $error("cfg spur");
  property p_seq;
    array_rd && seen_q |-> array_addr == nxt_q;
  endproperty
  a_seq: assert property (p_seq) else $error("addr skip");
  // Two sync stages plus state update fit inside five samples
  property p_oe_end;
    cs_n_pin [*5] |-> !boot_dout_oe;
  endproperty
  a_oe_end: assert property (p_oe_end) else $error("oe stuck");
endmodule
bind pbe_regs pbe_props #(
  .NUM_SECTORS(NUM_SECTORS),
  .SEC_W(SEC_W)
) u_props (.*);

//--- test/pbe_host.sv
`timescale 1ns/100ps
module pbe_host (
  input  wire        clock,
  input  wire        array_rd,
  input  wire [31:0] array_addr,
  output reg  [7:0]  array_rdata,
  input  wire [7:0]  boot_dout,
  output reg         cs_n_pin,
  output reg         sck_pin
);
  reg [7:0] seen [0:15];
  integer   i;
  initial begin
    array_rdata = 8'h00;
    cs_n_pin    = 1'b1;
    sck_pin     = 1'b0;
  end
  // Byte valid one cycle after request; toggles otherwise
  always @(posedge clock) begin
    if (array_rd) begin
      array_rdata <= array_addr[7:0] ^ 8'hA5;
    end else begin
      array_rdata <= ~array_rdata;
    end
  end
  // Six-clock sck levels leave room for sync and detect lag
  task boot(input integer n);
    begin
      cs_n_pin = 1'b0;
      repeat (6) @(negedge clock);
      for (i = 1; i <= n; i = i + 1) begin
        sck_pin = 1'b1;
        repeat (6) @(negedge clock);
        sck_pin = 1'b0;
        repeat (6) @(negedge clock);
        seen[i] = boot_dout;
      end
      cs_n_pin = 1'b1;
      repeat (8) @(negedge clock);
    end
  endtask
endmodule

//--- test/tb.sv
`timescale 1ns/100ps
module tb;
  localparam IMG = 32'h00000A0B;
  reg         clock, sys_rst, reg_rd, reg_wr;
  reg         erase_done, erase_ok, count_corrupt;
  reg  [1:0]  reg_sel;
  reg  [2:0]  reg_sector, erase_sector, corrupt_sector;
  reg  [31:0] reg_wdata, nv_cfg_image;
  wire [31:0] reg_rdata, nv_cfg_wdata, array_addr;
  wire [7:0]  array_rdata, boot_dout, sector_unlocked;
  wire        reg_rvalid, nv_cfg_wr, cs_n_pin, sck_pin;
  wire        array_rd, boot_dout_oe, boot_busy;
  integer     err_total, n_checks, i, k;
  pbe_regs #(.NUM_SECTORS(8), .SEC_W(3)) DUT (
    .clock(clock), .sys_rst(sys_rst), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_sector(reg_sector),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .nv_cfg_image(nv_cfg_image),
    .nv_cfg_wdata(nv_cfg_wdata), .nv_cfg_wr(nv_cfg_wr),
    .sector_unlocked(sector_unlocked), .erase_done(erase_done),
    .erase_ok(erase_ok), .erase_sector(erase_sector),
    .count_corrupt(count_corrupt), .corrupt_sector(corrupt_sector),
    .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .array_rd(array_rd),
    .array_addr(array_addr), .array_rdata(array_rdata),
    .boot_dout(boot_dout), .boot_dout_oe(boot_dout_oe),
    .boot_busy(boot_busy));
  pbe_host u_host (
    .clock(clock), .array_rd(array_rd), .array_addr(array_addr),
    .array_rdata(array_rdata), .boot_dout(boot_dout),
    .cs_n_pin(cs_n_pin), .sck_pin(sck_pin));
  always #50 clock = ~clock;
  task conclude;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wr(input [1:0] s, input [2:0] sec, input [31:0] d);
    begin
      reg_sel = s;
      reg_sector = sec;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clock);
      reg_wr = 1'b0;
    end
  endtask
  task rc(input [1:0] s, input [2:0] sec, input [31:0] e);
    begin
      reg_sel = s;
      reg_sector = sec;
      reg_rd = 1'b1;
      @(negedge clock);
      reg_rd = 1'b0;
      k = 0;
      while (reg_rvalid !== 1'b1 && k < 8) begin
        @(negedge clock);
        k = k + 1;
      end
      if (k == 8) begin
        err_total = err_total + 1;
        conclude;
      end else begin
        chk("rdata", e, reg_rdata);
        @(negedge clock);
      end
    end
  endtask
  task ev(input ok, input bad, input [2:0] sec);
    begin
      erase_done = ok | ~bad;
      erase_ok = ok;
      count_corrupt = bad;
      erase_sector = sec;
      corrupt_sector = sec;
      @(negedge clock);
      erase_done = 1'b0;
      count_corrupt = 1'b0;
      repeat (3) @(negedge clock);
    end
  endtask
  initial begin
    {clock, reg_rd, reg_wr, erase_done, erase_ok} = 5'h00;
    {count_corrupt, reg_sel, reg_sector} = 6'h00;
    {erase_sector, corrupt_sector, reg_wdata} = 38'h0;
    sys_rst = 1'b1;
    nv_cfg_image = IMG;
    err_total = 0;
    n_checks = 0;
    repeat (6) @(negedge clock);
    sys_rst = 1'b0;
    u_host.boot(9);
    for (i = 0; i < 4; i = i + 1)
      chk("boot", i ^ 8'hA5, u_host.seen[6 + i]);
    chk("oe", 0, boot_dout_oe);
    chk("busy", 0, boot_busy);
    $display("test boot done");
    rc(2'h1, 3'h0, IMG);
    rc(2'h0, 3'h0, 32'hFF);
    rc(2'h2, 3'h3, 0);
    rc(2'h3, 3'h0, 0);
    $display("test reset done");
    wr(2'h0, 3'h2, 32'h00);
    rc(2'h0, 3'h2, 0);
    chk("unlocked", 8'hFB, sector_unlocked);
    wr(2'h0, 3'h2, 32'h5A);
    rc(2'h0, 3'h2, 0);
    wr(2'h0, 3'h2, 32'hFF);
    rc(2'h0, 3'h2, 32'hFF);
    wr(2'h1, 3'h0, 32'h12345679);
    rc(2'h1, 3'h0, 32'h12345679);
    $display("test regs done");
    ev(1'b1, 1'b0, 3'h3);
    ev(1'b1, 1'b0, 3'h3);
    ev(1'b0, 1'b0, 3'h3);
    rc(2'h2, 3'h3, 2);
    rc(2'h2, 3'h4, 0);
    ev(1'b0, 1'b1, 3'h3);
    rc(2'h2, 3'h3, 32'h800000);
    wr(2'h2, 3'h3, 32'hFFFFFF);
    rc(2'h2, 3'h3, 32'h800000);
    ev(1'b1, 1'b0, 3'h3);
    rc(2'h2, 3'h3, 1);
    ev(1'b1, 1'b1, 3'h3);
    rc(2'h2, 3'h3, 32'h800000);
    $display("test erase done");
    nv_cfg_image = 32'h00000000;
    sys_rst = 1'b1;
    repeat (6) @(negedge clock);
    sys_rst = 1'b0;
    repeat (3) @(negedge clock);
    chk("busy", 0, boot_busy);
    rc(2'h1, 3'h0, 0);
    rc(2'h0, 3'h2, 32'hFF);
    $display("test reboot done");
    nv_cfg_image = 32'h00000201;
    sys_rst = 1'b1;
    repeat (6) @(negedge clock);
    sys_rst = 1'b0;
    u_host.boot(3);
    for (i = 0; i < 3; i = i + 1)
      chk("boot0", i ^ 8'hA5, u_host.seen[1 + i]);
    chk("oe", 32'h0, boot_dout_oe);
    $display("test nodelay done");
    conclude;
  end
endmodule
